// ==== pkg/pslave_pkg.sv ====
// package for the byte-wide slave port: bit positions, reset values, phase codes
// assumes a single 25 MHz clock and a synchronous active-low reset
//
// Functional notes
// - divide the clock by four into four phases; one cycle spans all four
// - slave enable bit 4 of direction register makes data pins a slave port
// - in slave mode pin 0 is read strobe, pin 1 write, pin 2 chip select
// - two latches at one address: firmware writes output, reads input latch
// - in slave mode the data direction register is ignored
// - external write begins with chip select and write strobe both low
// - strobe release sets input full flag in phase four after next phase two
// - write completion sets interrupt flag in the same phase four
// - input full flag clears only on a firmware read of the input latch or with slave mode disabled
// - write while previous byte unread sets the input overflow flag
// - external read start clears the output full flag at once
// - read strobe release sets interrupt flag in phase four after next phase two
// - output full stays clear until firmware writes the output latch
// - slave mode disabled forces input full and output full flags clear
// - leaving slave mode keeps overflow flag; firmware must clear it
// - interrupt flag stays until firmware clears; enable bit gates interrupt
package pslave_pkg;
   localparam int DATA_W = 8;
   // bit positions inside the port E direction register
   localparam int IN_FULL_BIT = 7;
   localparam int OUT_FULL_BIT = 6;
   localparam int IN_OVF_BIT = 5;
   localparam int MODE_BIT = 4;
   // bit positions inside the flag and enable registers
   localparam int IRQ_BIT = 7;
   localparam logic [1:0] PHASE_ONE = 2'h0;
   localparam logic [1:0] PHASE_TWO = 2'h1;
   localparam logic [1:0] PHASE_THREE = 2'h2;
   localparam logic [1:0] PHASE_FOUR = 2'h3;
   localparam logic [1:0] PHASE_RST = 2'h0;
   localparam logic [7:0] LATCH_RST = 8'h00;
   typedef enum logic [1:0] {DONE_IDLE, DONE_WAIT_P2, DONE_WAIT_P4} done_t;
endpackage

// ==== rtl/byte_slave_port.sv ====
// byte-wide slave port: an external processor writes the input latch and reads
// the output latch using chip select, read and write strobes (active low)
// assumes strobes arrive asynchronously; firmware side is on clock_in
`timescale 1ns/1ps
module byte_slave_port
   import pslave_pkg::*;
(
   // clock and reset
   input wire logic clock_in,
   input wire logic resetn_in,
   // firmware control and access
   input wire logic slave_port_enable_in,
   input wire logic [7:0] fw_wdata_in,
   input wire logic fw_write_in,
   input wire logic fw_read_in,
   input wire logic fw_clr_overflow_in,
   input wire logic fw_clr_irq_in,
   input wire logic slave_port_irq_enable_in,
   output logic [7:0] fw_rdata_out,
   // port e strobe pins
   input wire logic read_strobe_n_in,
   input wire logic write_strobe_n_in,
   input wire logic chip_select_n_in,
   // data pins, split three ways
   input wire logic [7:0] data_pins_in,
   output logic [7:0] data_pins_out,
   output logic [7:0] data_pins_oe_out,
   // status
   output logic [1:0] phase_out,
   output logic input_full_flag_out,
   output logic output_full_flag_out,
   output logic input_overflow_flag_out,
   output logic slave_port_irq_flag_out,
   output logic irq_out
);
   logic [1:0] phase_r;
   logic [2:0] strb_meta_r, strb_sync_r;
   logic [7:0] data_meta_r, data_sync_r;
   logic wr_act_r, rd_act_r;
   logic [7:0] in_latch_r, out_latch_r;
   logic in_full_r, out_full_r, in_ovf_r, irqf_r;
   done_t wdone_r, rdone_r;
   logic wr_low, rd_low, wr_set, rd_set;
   // phase divider, free running
   always_ff @(posedge clock_in) begin
      if (!resetn_in) phase_r <= PHASE_RST;
      else phase_r <= phase_r + 2'h1;
   end
   // two-stage synchronisers on every pin input
   always_ff @(posedge clock_in) begin
      if (!resetn_in) begin
         strb_meta_r <= 3'h7;
         strb_sync_r <= 3'h7;
         data_meta_r <= LATCH_RST;
         data_sync_r <= LATCH_RST;
      end else begin
         strb_meta_r <= {chip_select_n_in, write_strobe_n_in, read_strobe_n_in};
         strb_sync_r <= strb_meta_r;
         data_meta_r <= data_pins_in;
         data_sync_r <= data_meta_r;
      end
   end
   assign wr_low = slave_port_enable_in && !strb_sync_r[2] && !strb_sync_r[1];
   assign rd_low = slave_port_enable_in && !strb_sync_r[2] && !strb_sync_r[0];
   // access tracking; input latch follows pins while write is held low
   always_ff @(posedge clock_in) begin
      if (!resetn_in) begin
         wr_act_r <= 1'b0;
         rd_act_r <= 1'b0;
         in_latch_r <= LATCH_RST;
      end else begin
         wr_act_r <= wr_low;
         rd_act_r <= rd_low;
         if (wr_low) in_latch_r <= data_sync_r;
      end
   end
   // completion sequencers: wait for next phase two, then act on phase four
   always_ff @(posedge clock_in) begin
      if (!resetn_in) begin
         wdone_r <= DONE_IDLE;
         rdone_r <= DONE_IDLE;
      end else begin
         case (wdone_r)
            DONE_IDLE: if (wr_act_r && !wr_low) wdone_r <= DONE_WAIT_P2;
            DONE_WAIT_P2: if (phase_r == PHASE_TWO) wdone_r <= DONE_WAIT_P4;
            DONE_WAIT_P4: if (phase_r == PHASE_FOUR) wdone_r <= DONE_IDLE;
            default: wdone_r <= DONE_IDLE;
         endcase
         case (rdone_r)
            DONE_IDLE: if (rd_act_r && !rd_low) rdone_r <= DONE_WAIT_P2;
            DONE_WAIT_P2: if (phase_r == PHASE_TWO) rdone_r <= DONE_WAIT_P4;
            DONE_WAIT_P4: if (phase_r == PHASE_FOUR) rdone_r <= DONE_IDLE;
            default: rdone_r <= DONE_IDLE;
         endcase
      end
   end
   assign wr_set = (wdone_r == DONE_WAIT_P4) && (phase_r == PHASE_FOUR);
   assign rd_set = (rdone_r == DONE_WAIT_P4) && (phase_r == PHASE_FOUR);
   // input full and overflow; set wins over a same-cycle firmware clear
   always_ff @(posedge clock_in) begin
      if (!resetn_in) begin
         in_full_r <= 1'b0;
         in_ovf_r <= 1'b0;
      end else begin
         if (!slave_port_enable_in) in_full_r <= 1'b0;
         else if (wr_set) in_full_r <= 1'b1;
         else if (fw_read_in) in_full_r <= 1'b0;
         if (wr_set && in_full_r && !fw_read_in) in_ovf_r <= 1'b1;
         else if (fw_clr_overflow_in) in_ovf_r <= 1'b0;
      end
   end
   // output latch and output full; external read start clears at once
   always_ff @(posedge clock_in) begin
      if (!resetn_in) begin
         out_latch_r <= LATCH_RST;
         out_full_r <= 1'b0;
      end else begin
         if (fw_write_in) out_latch_r <= fw_wdata_in;
         if (!slave_port_enable_in) out_full_r <= 1'b0;
         else if (rd_low && !rd_act_r) out_full_r <= 1'b0;
         else if (fw_write_in) out_full_r <= 1'b1;
      end
   end
   // interrupt flag, sticky until firmware clears; set wins
   always_ff @(posedge clock_in) begin
      if (!resetn_in) irqf_r <= 1'b0;
      else if (wr_set || rd_set) irqf_r <= 1'b1;
      else if (fw_clr_irq_in) irqf_r <= 1'b0;
   end
   // firmware read data from a flop: input latch
   always_ff @(posedge clock_in) begin
      if (!resetn_in) fw_rdata_out <= LATCH_RST;
      else fw_rdata_out <= in_latch_r;
   end
   // drive is raw pins so the bus sees data without sync lag; direction reg unused
   assign data_pins_oe_out = {DATA_W{slave_port_enable_in && !chip_select_n_in
                                      && !read_strobe_n_in}};
   assign data_pins_out = out_latch_r;
   assign phase_out = phase_r;
   assign input_full_flag_out = in_full_r;
   assign output_full_flag_out = out_full_r;
   assign input_overflow_flag_out = in_ovf_r;
   assign slave_port_irq_flag_out = irqf_r;
   assign irq_out = irqf_r && slave_port_irq_enable_in;
endmodule

// ==== tb/byte_slave_port_chk.sv ====
// checker for the byte slave port: phase, flag timing, gating and pin drive
// assumes a bind to the port module; sees only its ports
`timescale 1ns/1ps
module byte_slave_port_chk
   import pslave_pkg::*;
(
   // watched ports
   input wire logic clock_in, resetn_in, slave_port_enable_in, fw_read_in, fw_clr_irq_in,
   input wire logic fw_clr_overflow_in, slave_port_irq_enable_in, read_strobe_n_in,
   input wire logic chip_select_n_in, input_full_flag_out, output_full_flag_out,
   input wire logic input_overflow_flag_out, slave_port_irq_flag_out, irq_out,
   input wire logic [1:0] phase_out,
   input wire logic [7:0] data_pins_oe_out
);
   default clocking @(posedge clock_in); endclocking
   default disable iff (!resetn_in);
   a_phase_step: assert property ($past(resetn_in) |-> phase_out == $past(phase_out) + 2'h1)
      else $error("phase did not step by one");
   a_full_timing: assert property ($rose(input_full_flag_out) |->
      $past(phase_out) == PHASE_FOUR && slave_port_irq_flag_out)
      else $error("input full set off phase four or without irq flag");
   a_full_clear: assert property ($fell(input_full_flag_out) |->
      $past(fw_read_in) || !$past(slave_port_enable_in)) else $error("input full lost");
   a_flags_off: assert property (!slave_port_enable_in ##1 !slave_port_enable_in |->
      !input_full_flag_out && !output_full_flag_out) else $error("flags set while off");
   a_ovf_sticky: assert property (input_overflow_flag_out && !fw_clr_overflow_in |=>
      input_overflow_flag_out) else $error("overflow flag dropped");
   a_irq_sticky: assert property (slave_port_irq_flag_out && !fw_clr_irq_in |=>
      slave_port_irq_flag_out) else $error("irq flag dropped");
   a_irq_gate: assert property (irq_out == (slave_port_irq_flag_out && slave_port_irq_enable_in))
      else $error("irq not gated by enable");
   a_pin_drive: assert property (data_pins_oe_out ==
      {8{slave_port_enable_in && !chip_select_n_in && !read_strobe_n_in}})
      else $error("data pin enable wrong");
   cover property ($rose(input_overflow_flag_out));
   cover property ($fell(output_full_flag_out));
   cover property ($rose(irq_out));
endmodule

// ==== tb/ext_cpu.sv ====
// external cpu model: byte reads and writes on chip select and strobes
// assumes its task is entered just after a rising clock edge
`timescale 1ns/1ps
module ext_cpu (
   // clock, strobes, driven data and seen bus level
   input wire logic clock_in,
   output logic cs_n_out = 1'b1, wr_n_out = 1'b1, rd_n_out = 1'b1,
   output logic [7:0] data_out = 8'h00,
   input wire logic [7:0] bus_in
);
   // strobe pins are pure inputs to the port, as firmware must set up
   // one access; hold picks a prompt or a slow cpu
   task automatic access(input logic wr, input logic [7:0] d, input int hold,
      output logic [7:0] q);
      {cs_n_out, wr_n_out, rd_n_out} <= {1'b0, ~wr, wr}; // both low for a write
      data_out <= d;
      repeat (hold) @(posedge clock_in);
      q = bus_in;
      {cs_n_out, wr_n_out, rd_n_out} <= 3'h7;
      data_out <= ~d; // released lines show no stale byte
   endtask
endmodule

// ==== tb/test_byte_slave_port.sv ====
// testbench for the byte slave port: firmware pulses plus an external cpu model
// assumes the checker is bound to the port module
`timescale 1ns/1ps
module test_byte_slave_port;
   logic clock_in = 0, resetn_in = 0, slave_port_enable_in = 0, fw_write_in = 0, fw_read_in = 0;
   logic fw_clr_overflow_in = 0, fw_clr_irq_in = 0, slave_port_irq_enable_in = 0;
   logic read_strobe_n_in, write_strobe_n_in, chip_select_n_in, input_full_flag_out, irq_out;
   logic output_full_flag_out, input_overflow_flag_out, slave_port_irq_flag_out;
   logic [7:0] fw_wdata_in = 8'ha5, fw_rdata_out, data_pins_in, data_pins_out, data_pins_oe_out;
   logic [7:0] cpu_data, q, flags;
   logic [1:0] phase_out;
   int error_cnt = 0, checks = 0;
   // bus level: the port wins while it drives
   assign data_pins_in = (|data_pins_oe_out) ? data_pins_out : cpu_data;
   assign flags = {3'h0, input_full_flag_out, output_full_flag_out, input_overflow_flag_out,
      slave_port_irq_flag_out, irq_out};
   byte_slave_port dut (.*);
   ext_cpu cpu (.clock_in(clock_in), .cs_n_out(chip_select_n_in), .wr_n_out(write_strobe_n_in),
      .rd_n_out(read_strobe_n_in), .data_out(cpu_data), .bus_in(data_pins_in));
   // 40 ns clock
   initial begin
      forever #20 clock_in = ~clock_in;
   end
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   // one firmware pulse: write, read, clear overflow, clear irq
   task automatic fw(input logic [3:0] p);
      {fw_write_in, fw_read_in, fw_clr_overflow_in, fw_clr_irq_in} <= p;
      @(posedge clock_in);
      {fw_write_in, fw_read_in, fw_clr_overflow_in, fw_clr_irq_in} <= 4'h0;
      @(posedge clock_in);
   endtask
   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", checks, error_cnt);
      if (error_cnt == 0 && checks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   // flag waits are fixed: release to flag is at most nine cycles
   initial begin
      repeat (2) @(posedge clock_in);
      {resetn_in, slave_port_enable_in, slave_port_irq_enable_in} <= 3'h7;
      @(posedge clock_in);
      chk(flags, 8'h00);
      fw(4'h8);
      chk(flags, 8'h08);
      cpu.access(1'b0, 8'h00, 6, q);
      chk(q, 8'ha5);
      repeat (10) @(posedge clock_in);
      chk(flags, 8'h03);
      slave_port_irq_enable_in <= 1'b0;
      @(posedge clock_in);
      chk(flags, 8'h02);
      $display("read test done");
      cpu.access(1'b1, 8'h3c, 3, q);
      repeat (10) @(posedge clock_in);
      chk(flags, 8'h12);
      fw(4'h5);
      chk(fw_rdata_out, 8'h3c);
      chk(flags, 8'h00);
      $display("write test done");
      cpu.access(1'b1, 8'h11, 4, q);
      repeat (10) @(posedge clock_in);
      cpu.access(1'b1, 8'h22, 4, q);
      repeat (10) @(posedge clock_in);
      chk(flags, 8'h16);
      slave_port_enable_in <= 1'b0;
      repeat (2) @(posedge clock_in);
      chk(flags, 8'h06);
      fw(4'h3);
      cpu.access(1'b1, 8'h77, 4, q);
      repeat (10) @(posedge clock_in);
      chk(flags, 8'h00);
      $display("overflow test done");
      tally_and_finish();
   end
endmodule
bind byte_slave_port byte_slave_port_chk chk (.*);
